// ### src/iocr_pkg.sv
// Purpose: Shared constants for the I/O cell route select block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   All selections are static configuration words

package iocr_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_MODE = 8'h00;
  localparam logic [7:0]  ADR_OSEL = 8'h04;
  localparam logic [7:0]  ADR_TRI  = 8'h08;
  localparam logic [7:0]  ADR_LINK = 8'h0c;
  localparam logic [7:0]  ADR_BRG  = 8'h10;
  localparam logic [7:0]  ADR_STAT = 8'h14;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_INV_LSB   = 8;
  localparam int MODE_TSLOW_LSB = 12;
  localparam int MODE_SPINE_EN  = 16;
  localparam int MODE_SPINE_LSB = 17;
  localparam int MODE_SIDE_LR   = 19;
  localparam int OSEL_TS_LSB    = 8;
  localparam int LINK_LL_EN     = 0;
  localparam int LINK_LL_TGT    = 1;
  localparam int LINK_FAST_L    = 4;
  localparam int LINK_FAST_H    = 8;
  localparam int LINK_SGL_EXT   = 12;
  localparam int LINK_DBL_JOIN  = 16;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TS_LLDRV   = 3'h5;
  localparam logic [2:0] LL_TGT_PXL = 3'h4;

  typedef enum logic [1:0] {
    PM_INPUT, PM_TRI_OUT, PM_DIRECT_OUT, PM_BIDIR
  } iocr_pad_mode_t;

  typedef enum logic [2:0] {
    TM_OFF, TM_PAD_ARRAY, TM_PAD_PERIM, TM_ARRAY_PERIM, TM_PERIM_ARRAY
  } iocr_tri_mode_t;

endpackage

// ### src/iocr_pad_sel.sv
// Purpose: Output and drive enable selection for one pad
// Assumes: Source vectors are already shifted for this pad position
// Notes:   Purely combinational; the top registers the result

`timescale 1ns/1ps

module iocr_pad_sel (
  input  wire logic [1:0] mode_i,       // Pad mode
  input  wire logic [1:0] out_sel_i,    // Output source select
  input  wire logic [2:0] ts_sel_i,     // Drive enable source select
  input  wire logic       invert_i,     // Invert output data
  input  wire logic       ts_low_i,     // Enable is active low
  input  wire logic [3:0] out_src_i,    // Four output sources
  input  wire logic [5:0] ts_src_i,     // Six enable sources
  input  wire logic       direct_out_i, // Flip-flop direct output
  output logic            data_o,       // Pad data
  output logic            oe_o          // Pad output enable
);

  logic ts_raw;
  logic drive_en;

  always_comb begin
    // Codes 6 and 7 select nothing, so the drive enable stays off
    ts_raw   = (ts_sel_i < 3'h6) ? ts_src_i[ts_sel_i] : 1'b0;
    drive_en = (ts_sel_i < 3'h6) & (ts_raw ^ ts_low_i);
    data_o   = 1'b0;
    oe_o     = 1'b0;
    case (iocr_pkg::iocr_pad_mode_t'(mode_i))
      iocr_pkg::PM_INPUT: begin
        oe_o = 1'b0;
      end
      iocr_pkg::PM_DIRECT_OUT: begin
        data_o = direct_out_i ^ invert_i;
        oe_o   = 1'b1;
      end
      iocr_pkg::PM_TRI_OUT, iocr_pkg::PM_BIDIR: begin
        data_o = out_src_i[out_sel_i] ^ invert_i;
        oe_o   = drive_en;
      end
      default: begin
        oe_o = 1'b0;
      end
    endcase
  end

endmodule

// ### src/iocr_tri_buf.sv
// Purpose: One tridirectional buffer between pad, array and bridge
// Assumes: Bridge side is already steered to a perimeter track
// Notes:   Combinational; only one direction is driven per mode

`timescale 1ns/1ps

module iocr_tri_buf (
  input  wire logic [2:0] mode_i,      // Buffer direction mode
  input  wire logic       pad_i,       // Pad input value
  input  wire logic       array_i,     // Array track value
  input  wire logic       bridge_i,    // Bridge track value
  output logic            array_o,     // Drive onto array track
  output logic            array_oe_o,  // Array track enable
  output logic            bridge_o,    // Drive onto bridge track
  output logic            bridge_oe_o  // Bridge track enable
);

  always_comb begin
    array_o     = 1'b0;
    array_oe_o  = 1'b0;
    bridge_o    = 1'b0;
    bridge_oe_o = 1'b0;
    case (iocr_pkg::iocr_tri_mode_t'(mode_i))
      iocr_pkg::TM_PAD_ARRAY: begin
        array_o    = pad_i;
        array_oe_o = 1'b1;
      end
      iocr_pkg::TM_PAD_PERIM: begin
        bridge_o    = pad_i;
        bridge_oe_o = 1'b1;
      end
      iocr_pkg::TM_ARRAY_PERIM: begin
        bridge_o    = array_i;
        bridge_oe_o = 1'b1;
      end
      iocr_pkg::TM_PERIM_ARRAY: begin
        array_o    = bridge_i;
        array_oe_o = 1'b1;
      end
      default: begin
        array_oe_o = 1'b0;
      end
    endcase
  end

endmodule

// ### src/iocr_top.sv
// Purpose: Route selection of one perimeter I/O cell with four pads
// Assumes: Configuration written over classic Wishbone, one clock
// Notes:   All outputs registered, so routes show one cycle later

`timescale 1ns/1ps

// Function
// - each cell has four pads: input, tristate, direct output or bidir
// - pad inputs reach core on four-bit bus plus direct flip-flop bus
// - four direct paths carry flip-flop outputs straight to pad buffers
// - pad 0 enable picks from two long, singles 0/1, switch 0, line driver
// - pad 1 output picks switch 1, single 1, single 3 or double 2
// - direct inputs use separate top/bottom and left/right buses
// - any one of four pads may drive the dedicated clock spine
// - eight tridirectional buffers, four to long, four to half tracks
// - line driver from switch 4 reaches half tracks or long track 0 and enables
// - double tracks join two cells on; singles extend only when enabled
// - two long perimeter tracks span edge and twist through cells
// - four half perimeter tracks span half edge without twisting
// - perimeter tracks reach array only through perpendicular paths
// - bridges pass either way between perimeter and array tracks
// - eight-bit fast link puts pads directly on array long and half tracks
// - pad not driven by configuration stays high impedance
// - output invertible, drive enable active high or low
module iocr_top (
  input  wire logic        clk_i,          // Clock, 50 MHz
  input  wire logic        rst_i,          // Sync reset, active high
  input  wire logic        wb_cyc_i,       // Bus cycle
  input  wire logic        wb_stb_i,       // Bus strobe
  input  wire logic        wb_we_i,        // Write enable
  input  wire logic [7:0]  wb_adr_i,       // Byte address
  input  wire logic [3:0]  wb_sel_i,       // Byte lanes
  input  wire logic [31:0] wb_dat_i,       // Write data
  output logic      [31:0] wb_dat_o,       // Read data
  output logic             wb_ack_o,       // Acknowledge
  input  wire logic [3:0]  pad_in_i,       // Pad input levels
  output logic      [3:0]  pad_out_o,      // Pad output data
  output logic      [3:0]  pad_oe_o,       // Pad output enable
  input  wire logic [3:0]  direct_out_i,   // Flip-flop direct outputs
  input  wire logic [4:0]  switch_track_i, // Adjacent switch tracks
  output logic      [3:0]  core_in_o,      // Pad inputs to core
  output logic      [3:0]  direct_in_tb_o, // Direct in, top/bottom
  output logic      [3:0]  direct_in_lr_o, // Direct in, left/right
  output logic             clock_spine_o,  // Clock spine drive
  output logic             clock_spine_oe_o, // Clock spine enable
  input  wire logic [1:0]  plong_i,        // Perimeter long level
  output logic      [1:0]  plong_o,        // Perimeter long drive
  output logic      [1:0]  plong_oe_o,     // Perimeter long enable
  output logic      [1:0]  plong_next_o,   // Long tracks, twisted on
  input  wire logic [3:0]  phalf_i,        // Perimeter half level
  output logic      [3:0]  phalf_o,        // Perimeter half drive
  output logic      [3:0]  phalf_oe_o,     // Perimeter half enable
  output logic      [3:0]  phalf_next_o,   // Half tracks, passed on
  input  wire logic [3:0]  psingle_i,      // Perimeter single level
  output logic      [3:0]  psingle_o,      // Perimeter single drive
  output logic      [3:0]  psingle_oe_o,   // Perimeter single enable
  output logic      [3:0]  psingle_next_o, // Single extension data
  output logic      [3:0]  psingle_next_oe_o, // Single extension enable
  input  wire logic [3:0]  pdouble_i,      // Perimeter double level
  output logic      [3:0]  pdouble_next_o, // Double track past break
  output logic      [3:0]  pdouble_next_oe_o, // Double break closed
  input  wire logic [3:0]  along_i,        // Array long level
  output logic      [3:0]  along_o,        // Array long drive
  output logic      [3:0]  along_oe_o,     // Array long enable
  input  wire logic [3:0]  ahalf_i,        // Array half level
  output logic      [3:0]  ahalf_o,        // Array half drive
  output logic      [3:0]  ahalf_oe_o      // Array half enable
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] cfg_mode;
  logic [31:0] cfg_osel;
  logic [31:0] cfg_tri;
  logic [31:0] cfg_link;
  logic [31:0] cfg_brg;
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] next_dat;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;

  // Selections only change on reset or a bus write, never on their own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_mode <= iocr_pkg::CFG_RST;
      cfg_osel <= iocr_pkg::CFG_RST;
      cfg_tri  <= iocr_pkg::CFG_RST;
      cfg_link <= iocr_pkg::CFG_RST;
      cfg_brg  <= iocr_pkg::CFG_RST;
    end else if (bus_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          case (wb_adr_i)
            iocr_pkg::ADR_MODE: cfg_mode[8*b +: 8] <= wb_dat_i[8*b +: 8];
            iocr_pkg::ADR_OSEL: cfg_osel[8*b +: 8] <= wb_dat_i[8*b +: 8];
            iocr_pkg::ADR_TRI:  cfg_tri[8*b +: 8]  <= wb_dat_i[8*b +: 8];
            iocr_pkg::ADR_LINK: cfg_link[8*b +: 8] <= wb_dat_i[8*b +: 8];
            iocr_pkg::ADR_BRG:  cfg_brg[8*b +: 8]  <= wb_dat_i[8*b +: 8];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait-free cycle, unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    case (wb_adr_i)
      iocr_pkg::ADR_MODE: next_dat = cfg_mode;
      iocr_pkg::ADR_OSEL: next_dat = cfg_osel;
      iocr_pkg::ADR_TRI:  next_dat = cfg_tri;
      iocr_pkg::ADR_LINK: next_dat = cfg_link;
      iocr_pkg::ADR_BRG:  next_dat = cfg_brg;
      iocr_pkg::ADR_STAT: next_dat = {20'h0_0000, clock_spine_oe_o,
                                      3'h0, pad_oe_o, core_in_o};
      default:            next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_dat : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Long-line driver and pad selectors
  // ----------------------------------------------------------------
  logic       lldrv;
  logic [3:0] next_pad_out;
  logic [3:0] next_pad_oe;

  assign lldrv = switch_track_i[4];

  for (genvar p = 0; p < 4; p++) begin : g_pad
    logic [3:0] out_src;
    logic [5:0] ts_src;
    // Pad 1 order is switch 1, single 1, single 3, double 2
    assign out_src = {pdouble_i[(p + 1) % 4], psingle_i[(p + 2) % 4],
                      psingle_i[p], switch_track_i[p]};
    // Pad 0 order is long 0, long 1, single 0, single 1, switch 0, driver
    assign ts_src = {lldrv, switch_track_i[p], psingle_i[(p + 1) % 4],
                     psingle_i[p], plong_i[1], plong_i[0]};

    iocr_pad_sel u_pad_sel (
      .mode_i       (cfg_mode[2*p +: 2]),
      .out_sel_i    (cfg_osel[2*p +: 2]),
      .ts_sel_i     (cfg_osel[iocr_pkg::OSEL_TS_LSB + 3*p +: 3]),
      .invert_i     (cfg_mode[iocr_pkg::MODE_INV_LSB + p]),
      .ts_low_i     (cfg_mode[iocr_pkg::MODE_TSLOW_LSB + p]),
      .out_src_i    (out_src),
      .ts_src_i     (ts_src),
      .direct_out_i (direct_out_i[p]),
      .data_o       (next_pad_out[p]),
      .oe_o         (next_pad_oe[p])
    );
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= 4'h0;
      pad_oe_o  <= 4'h0;
    end else begin
      pad_out_o <= next_pad_out;
      pad_oe_o  <= next_pad_oe;
    end
  end

  // ----------------------------------------------------------------
  // Input paths and clock spine
  // ----------------------------------------------------------------
  logic [1:0] spine_sel;
  logic       spine_en;

  assign spine_sel = cfg_mode[iocr_pkg::MODE_SPINE_LSB +: 2];
  assign spine_en  = cfg_mode[iocr_pkg::MODE_SPINE_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_in_o        <= 4'h0;
      direct_in_tb_o   <= 4'h0;
      direct_in_lr_o   <= 4'h0;
      clock_spine_o    <= 1'b0;
      clock_spine_oe_o <= 1'b0;
    end else begin
      core_in_o <= pad_in_i;
      // The unused side bus is held low so it loads nothing
      direct_in_lr_o <= cfg_mode[iocr_pkg::MODE_SIDE_LR] ?
                        pad_in_i : 4'h0;
      direct_in_tb_o <= cfg_mode[iocr_pkg::MODE_SIDE_LR] ?
                        4'h0 : pad_in_i;
      // One select field means one pad at most; the far cell is
      // software's to keep quiet
      clock_spine_o    <= spine_en & pad_in_i[spine_sel];
      clock_spine_oe_o <= spine_en;
    end
  end

  // ----------------------------------------------------------------
  // Tridirectional buffers and bridge tracks
  // ----------------------------------------------------------------
  // Perimeter tracks never touch array tracks except through here
  logic [7:0] brg_in;
  logic [7:0] brg_out;
  logic [7:0] brg_oe;
  logic [7:0] arr_out;
  logic [7:0] arr_oe;

  for (genvar b = 0; b < 8; b++) begin : g_tri
    logic [1:0] psel;
    logic       arr_lvl;
    assign psel    = cfg_brg[2*b +: 2];
    assign arr_lvl = (b < 4) ? along_i[b % 4] : ahalf_i[b % 4];
    always_comb begin
      case (psel)
        2'h0:    brg_in[b] = plong_i[b % 2];
        2'h1:    brg_in[b] = phalf_i[b % 4];
        2'h2:    brg_in[b] = psingle_i[b % 4];
        default: brg_in[b] = 1'b0;
      endcase
    end

    iocr_tri_buf u_tri (
      .mode_i      (cfg_tri[3*b +: 3]),
      .pad_i       (pad_in_i[b % 4]),
      .array_i     (arr_lvl),
      .bridge_i    (brg_in[b]),
      .array_o     (arr_out[b]),
      .array_oe_o  (arr_oe[b]),
      .bridge_o    (brg_out[b]),
      .bridge_oe_o (brg_oe[b])
    );
  end

  // ----------------------------------------------------------------
  // Track drive merge
  // ----------------------------------------------------------------
  logic [1:0] next_pl;
  logic [1:0] next_pl_oe;
  logic [3:0] next_ph;
  logic [3:0] next_ph_oe;
  logic [3:0] next_ps;
  logic [3:0] next_ps_oe;
  logic [3:0] next_al;
  logic [3:0] next_al_oe;
  logic [3:0] next_ah;
  logic [3:0] next_ah_oe;
  logic [2:0] ll_tgt;

  assign ll_tgt = cfg_link[iocr_pkg::LINK_LL_TGT +: 3];

  always_comb begin
    next_pl    = 2'h0;
    next_pl_oe = 2'h0;
    next_ph    = 4'h0;
    next_ph_oe = 4'h0;
    next_ps    = 4'h0;
    next_ps_oe = 4'h0;
    for (int b = 0; b < 8; b++) begin
      if (brg_oe[b]) begin
        case (cfg_brg[2*b +: 2])
          2'h0: begin
            next_pl[b % 2]    = next_pl[b % 2] | brg_out[b];
            next_pl_oe[b % 2] = 1'b1;
          end
          2'h1: begin
            next_ph[b % 4]    = next_ph[b % 4] | brg_out[b];
            next_ph_oe[b % 4] = 1'b1;
          end
          2'h2: begin
            next_ps[b % 4]    = next_ps[b % 4] | brg_out[b];
            next_ps_oe[b % 4] = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    if (cfg_link[iocr_pkg::LINK_LL_EN]) begin
      if (ll_tgt == iocr_pkg::LL_TGT_PXL) begin
        next_pl[0]    = next_pl[0] | lldrv;
        next_pl_oe[0] = 1'b1;
      end else if (ll_tgt < iocr_pkg::LL_TGT_PXL) begin
        next_ph[ll_tgt[1:0]]    = next_ph[ll_tgt[1:0]] | lldrv;
        next_ph_oe[ll_tgt[1:0]] = 1'b1;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      next_al[p]    = arr_out[p] | (cfg_link[iocr_pkg::LINK_FAST_L + p]
                      & pad_in_i[p]);
      next_al_oe[p] = arr_oe[p] | cfg_link[iocr_pkg::LINK_FAST_L + p];
      next_ah[p]    = arr_out[p + 4] | (cfg_link[iocr_pkg::LINK_FAST_H + p]
                      & pad_in_i[p]);
      next_ah_oe[p] = arr_oe[p + 4] | cfg_link[iocr_pkg::LINK_FAST_H + p];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plong_o      <= 2'h0;
      plong_oe_o   <= 2'h0;
      phalf_o      <= 4'h0;
      phalf_oe_o   <= 4'h0;
      psingle_o    <= 4'h0;
      psingle_oe_o <= 4'h0;
      along_o      <= 4'h0;
      along_oe_o   <= 4'h0;
      ahalf_o      <= 4'h0;
      ahalf_oe_o   <= 4'h0;
    end else begin
      plong_o      <= next_pl;
      plong_oe_o   <= next_pl_oe;
      phalf_o      <= next_ph;
      phalf_oe_o   <= next_ph_oe;
      psingle_o    <= next_ps;
      psingle_oe_o <= next_ps_oe;
      along_o      <= next_al;
      along_oe_o   <= next_al_oe;
      ahalf_o      <= next_ah;
      ahalf_oe_o   <= next_ah_oe;
    end
  end

  // ----------------------------------------------------------------
  // Pass-through to the neighbouring cell
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plong_next_o      <= 2'h0;
      phalf_next_o      <= 4'h0;
      psingle_next_o    <= 4'h0;
      psingle_next_oe_o <= 4'h0;
      pdouble_next_o    <= 4'h0;
      pdouble_next_oe_o <= 4'h0;
    end else begin
      plong_next_o      <= {plong_i[0], plong_i[1]};
      phalf_next_o      <= phalf_i;
      psingle_next_o    <= psingle_i &
                           cfg_link[iocr_pkg::LINK_SGL_EXT +: 4];
      psingle_next_oe_o <= cfg_link[iocr_pkg::LINK_SGL_EXT +: 4];
      // Break only matters at the second cell of each double span
      pdouble_next_o    <= pdouble_i &
                           cfg_link[iocr_pkg::LINK_DBL_JOIN +: 4];
      pdouble_next_oe_o <= cfg_link[iocr_pkg::LINK_DBL_JOIN +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic in_mode0;
  logic dir_mode1;
  logic tri_mode1;
  assign in_mode0  = cfg_mode[1:0] == 2'h0;
  assign dir_mode1 = cfg_mode[3:2] == 2'h2;
  assign tri_mode1 = cfg_mode[3:2] == 2'h1;

  a_input_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
    in_mode0 ##1 in_mode0 |-> !pad_oe_o[0])
    else $error("pad 0 driven in input mode");
  a_direct_out: assert property (@(posedge clk_i) disable iff (rst_i)
    dir_mode1 |=> pad_oe_o[1] &&
    pad_out_o[1] == ($past(direct_out_i[1]) ^ $past(cfg_mode[9])))
    else $error("direct output path wrong");
  a_pad1_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    tri_mode1 && cfg_osel[3:2] == 2'h2 && !cfg_mode[9] |=>
    pad_out_o[1] == $past(psingle_i[3]))
    else $error("pad 1 output source wrong");
  a_ts_lldrv: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_mode[1:0] == 2'h1 && cfg_osel[10:8] == 3'h5 && !cfg_mode[12]
    |=> pad_oe_o[0] == $past(switch_track_i[4]))
    else $error("pad 0 enable not from line driver");
  a_ts_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_mode[1:0] == 2'h1 && cfg_osel[10:8] > 3'h5 |=> !pad_oe_o[0])
    else $error("pad 0 enabled by invalid select");
  a_core_in: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> core_in_o == $past(pad_in_i))
    else $error("core input bus lags");
  a_spine_src: assert property (@(posedge clk_i) disable iff (rst_i)
    spine_en && spine_sel == 2'h2 |=> clock_spine_oe_o &&
    clock_spine_o == $past(pad_in_i[2]))
    else $error("clock spine source wrong");
  a_long_twist: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> plong_next_o[1] == $past(plong_i[0]) &&
    plong_next_o[0] == $past(plong_i[1]))
    else $error("long tracks not twisted");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a one-cycle answer");

  c_direct: cover property (@(posedge clk_i) dir_mode1 ##1 pad_oe_o[1]);
  c_spine: cover property (@(posedge clk_i) clock_spine_oe_o);
  c_write: cover property (@(posedge clk_i) bus_wr ##1 wb_ack_o);
  c_bridge: cover property (@(posedge clk_i) |brg_oe ##1 |phalf_oe_o);

endmodule

// ### sim/iocr_lc_model.sv
// Purpose: Adjacent logic cell as seen from the I/O cell
// Assumes: Bench sets the levels the cell puts on its tracks
// Notes:   Combinational, so no extra route latency is added

`timescale 1ns/1ps

module iocr_lc_model (
  input  wire logic [8:0] pat_i,    // Levels to put out
  output logic      [4:0] switch_o, // Switch tracks 0..4
  output logic      [3:0] dout_o    // Flip-flop direct outputs
);
  assign switch_o = pat_i[4:0];
  assign dout_o   = pat_i[8:5];
endmodule

// ### sim/iocr_top_tb.sv
// Purpose: Self-checking bench for the I/O cell route select
// Assumes: One Wishbone master, one pad pattern at a time
// Notes:   Routes are registered, so every check waits two edges

`timescale 1ns/1ps

module iocr_top_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed nets
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sp, spoe;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, rdat;
  logic [3:0]  pad = 4'h0, ps = 4'h0, pd = 4'h0, po, poe, cin, dtb;
  logic [3:0]  dlr, dout, ph, phoe, al, aloe, psn, pdn;
  logic [1:0]  pl = 2'h0, pln;
  logic [8:0]  pat = 9'h0;
  logic [4:0]  sw;
  int          mismatches = 0, checks_done = 0, cyc_n = 0;
  int          p0[6] = '{4, 5, 0, 1, 6, 10};
  int          p1[4] = '{7, 1, 3, 13};

  initial forever #10 clk_i = ~clk_i;

  iocr_lc_model i_iocr_lc_model (.pat_i(pat), .switch_o(sw), .dout_o(dout));

  iocr_top i_iocr_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pad), .pad_out_o(po),
    .pad_oe_o(poe), .direct_out_i(dout), .switch_track_i(sw),
    .core_in_o(cin), .direct_in_tb_o(dtb), .direct_in_lr_o(dlr),
    .clock_spine_o(sp), .clock_spine_oe_o(spoe), .plong_i(pl),
    .plong_o(), .plong_oe_o(), .plong_next_o(pln), .phalf_i(4'h0),
    .phalf_o(ph), .phalf_oe_o(phoe), .phalf_next_o(), .psingle_i(ps),
    .psingle_o(), .psingle_oe_o(), .psingle_next_o(psn),
    .psingle_next_oe_o(), .pdouble_i(pd), .pdouble_next_o(pdn),
    .pdouble_next_oe_o(), .along_i(4'h0), .along_o(al), .along_oe_o(aloe),
    .ahalf_i(4'h0), .ahalf_o(), .ahalf_oe_o());

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  // Two edges: one to sample the inputs, one to see the result
  task automatic drv(input logic [18:0] v);
    {pat[8:5], pd, pat[4:0], pl, ps} <= v;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, iocr_pkg::ADR_MODE, 32'h0);
    chk(q, iocr_pkg::CFG_RST);
    chk({28'h0, poe}, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, iocr_pkg::ADR_LINK, 32'h1);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h1);
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, iocr_pkg::ADR_OSEL, 32'(c) << 8);
      drv(19'h1 << p0[c]);
      chk({31'h0, poe[0]}, 32'h1);
    end
    wb(1'b1, iocr_pkg::ADR_OSEL, 32'h600);
    chk({31'h0, poe[0]}, 32'h0);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h1001);
    wb(1'b1, iocr_pkg::ADR_OSEL, 32'h0);
    drv(19'h10);
    chk({31'h0, poe[0]}, 32'h0);
    drv(19'h0);
    chk({31'h0, poe[0]}, 32'h1);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h4);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, iocr_pkg::ADR_OSEL, 32'(c) << 2);
      drv(19'h1 << p1[c]);
      chk({31'h0, po[1]}, 32'h1);
    end
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h204);
    drv(19'h0);
    chk({31'h0, po[1]}, 32'h1);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h28);
    drv(19'h4 << 15);
    chk({28'h0, po[2:1], poe[2:1]}, 32'hb);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h0);
    pad <= 4'ha;
    drv(19'h0);
    chk({20'h0, cin, dtb, dlr}, 32'haa0);
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h80000);
    chk({24'h0, dtb, dlr}, 32'h0a);
    pad <= 4'h4;
    // Only one pad drives the spine, as the far cell shares it
    wb(1'b1, iocr_pkg::ADR_MODE, 32'h50000);
    chk({30'h0, sp, spoe}, 32'h3);
    wb(1'b0, iocr_pkg::ADR_STAT, 32'h0);
    chk(q, 32'h804);
    drv(19'h10);
    chk({30'h0, pln}, 32'h2);
    drv(19'h400);
    chk({24'h0, ph, phoe}, 32'h11);
    pad <= 4'h1;
    wb(1'b1, iocr_pkg::ADR_LINK, 32'h10);
    chk({24'h0, al, aloe}, 32'h11);
    wb(1'b1, iocr_pkg::ADR_BRG, 32'h100);
    wb(1'b1, iocr_pkg::ADR_TRI, 32'h2000);
    chk({24'h0, ph, phoe}, 32'h11);
    wb(1'b1, iocr_pkg::ADR_LINK, 32'h11010);
    drv(19'h1803);
    chk({24'h0, psn, pdn}, 32'h11);
    tally_and_finish();
  end
endmodule
